// ---- cct_map.svh ----
// register indices, field positions, reset values and timing counts of the capture/compare timer
`ifndef CCT_MAP_SVH
`define CCT_MAP_SVH

// ----------------------------------------
// register indices (byte address = 4 * index)
// ----------------------------------------
`define CCT_IDX_CTL     6'h12
`define CCT_IDX_FLG     6'h13
`define CCT_IDX_CAP_HI  6'h14
`define CCT_IDX_CAP_LO  6'h15
`define CCT_IDX_CMP_HI  6'h16
`define CCT_IDX_CMP_LO  6'h17
`define CCT_IDX_CNT_HI  6'h18
`define CCT_IDX_CNT_LO  6'h19
`define CCT_IDX_ALT_HI  6'h1a
`define CCT_IDX_ALT_LO  6'h1b

// ----------------------------------------
// field positions
// ----------------------------------------
`define CCT_BIT_CAP     7
`define CCT_BIT_CMP     6
`define CCT_BIT_OVF     5
`define CCT_BIT_EDGE    1
`define CCT_BIT_LEVEL   0

// ----------------------------------------
// reset values and counts
// ----------------------------------------
`define CCT_CTL_RST     8'h00
`define CCT_CNT_RST     16'h0000
`define CCT_PRESC_LAST  2'h3
`define CCT_CNT_MAX     16'hffff

`endif

// ---- cct_pkg.sv ----
// types shared by the capture/compare timer
package cct_pkg;

    // control register layout
    typedef struct packed {
        logic       cap_irq_enable;
        logic       compare_irq_enable;
        logic       overflow_irq_enable;
        logic [2:0] rsvd;
        logic       capture_edge_select;
        logic       output_level_bit;
    } cct_ctl_t;

    // flag register layout, also the interrupt mask layout
    typedef struct packed {
        logic       capture_flag;
        logic       compare_flag;
        logic       overflow_flag;
        logic [4:0] rsvd;
    } cct_flg_t;

endpackage : cct_pkg

// ---- cct_sync_edge.sv ----
// two-flop synchroniser with edge detection for the capture pin
`timescale 1ns/1ps
module cct_sync_edge (
    // clock
    input  wire logic clk,
    // asynchronous pin
    input  wire logic pin,
    // edges, one cycle each
    output logic      rise,
    output logic      fall
);
    logic s1_q;
    logic s2_q;
    logic s3_q;

    // ----------------------------------------
    // synchroniser
    // ----------------------------------------
    // two flops, then edge
    always_ff @(posedge clk) begin
        s1_q <= pin;
        s2_q <= s1_q;
        s3_q <= s2_q;
    end

    assign rise = s2_q & ~s3_q;
    assign fall = ~s2_q & s3_q;

endmodule : cct_sync_edge

// ---- cct_timer.sv ----
// 16-bit capture/compare timer with wishbone register access
// Functional notes
// - counter counts once every four clocks, fixed prescale, wraps to zero
// - counter reads never disturb counting
// - every 16-bit quantity appears as high and low byte registers
// - active capture edge copies the counter into the capture pair
// - edge select: 1 rising, 0 falling; reset leaves it alone
// - compare evaluated once every fourth clock, once per count value
// - match drives compare pin to output level bit; reset clears that bit
// - capture irq enable, read/write, reset clear, requests on capture
// - compare irq enable, read/write, reset clear, requests on match
// - overflow irq enable, read/write, reset clear, requests on wrap
// - capture flag: set on edge, cleared by status read then capture low read
// - compare flag: set on match, cleared by status read then compare low access
// - overflow flag: set on wrap, cleared by status read then counter low read
// - counter high read freezes low byte until read; writes ignored
// - capture high read inhibits capture until low read; writes ignored
// - compare high write inhibits matches until compare low write
// - second counter view latches alike and never clears overflow flag
//
// Added by the designer: the Wishbone slave port.
`timescale 1ns/1ps
`include "cct_map.svh"
module cct_timer (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // pins
    input  wire logic        capture_in_pin,
    output logic             compare_out_pin,
    // interrupt
    output logic             timer_irq
);
    // ----------------------------------------
    // state
    // ----------------------------------------
    cct_pkg::cct_ctl_t ctl_q;
    cct_pkg::cct_flg_t flg_q;
    logic [1:0]  presc_q;
    logic [15:0] cnt_q;
    logic [15:0] cap_q;
    logic [15:0] cmp_q;
    logic [7:0]  cnt_lat_q;
    logic        cnt_frz_q;
    logic [7:0]  alt_lat_q;
    logic        alt_frz_q;
    logic        cap_inh_q;
    logic        cmp_inh_q;
    logic        arm_cap_q;
    logic        arm_cmp_q;
    logic        arm_ovf_q;
    logic        ack_q;
    logic [31:0] dat_q;
    logic        pin_q;
    logic        irq_q;

    // ----------------------------------------
    // bus decode
    // ----------------------------------------
    logic       acc;
    logic       rd;
    logic       wr;
    logic [5:0] idx;
    logic       tick;
    logic       wrap;
    logic       cap_rise;
    logic       cap_fall;
    logic       cap_evt;
    logic       cmp_match;
    logic [7:0] rdata;

    assign acc  = wb_cyc_i & wb_stb_i & ~ack_q;
    assign rd   = acc & ~wb_we_i;
    assign wr   = acc & wb_we_i & wb_sel_i[0];
    assign idx  = wb_adr_i[7:2];
    assign tick = (presc_q == `CCT_PRESC_LAST);
    assign wrap = tick & (cnt_q == `CCT_CNT_MAX);

    function automatic logic hit(input logic [5:0] a, input logic [5:0] r);
        hit = (a == r);
    endfunction : hit

    // ----------------------------------------
    // capture pin front end
    // ----------------------------------------
    cct_sync_edge u_sync (
        .clk  (clk),
        .pin  (capture_in_pin),
        .rise (cap_rise),
        .fall (cap_fall)
    );

    assign cap_evt = ctl_q.capture_edge_select ? cap_rise : cap_fall;

    // ----------------------------------------
    // prescaler and counter
    // ----------------------------------------
    // divide by four
    always_ff @(posedge clk) begin
        if (rst) begin
            presc_q <= 2'h0;
        end else begin
            presc_q <= presc_q + 2'h1;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            cnt_q <= `CCT_CNT_RST;
        end else if (tick) begin
            cnt_q <= cnt_q + 16'h0001;
        end
    end

    // ----------------------------------------
    // control register
    // ----------------------------------------
    // enables, level clear, edge kept
    always_ff @(posedge clk) begin
        if (rst) begin
            ctl_q.cap_irq_enable      <= 1'b0;
            ctl_q.compare_irq_enable  <= 1'b0;
            ctl_q.overflow_irq_enable <= 1'b0;
            ctl_q.rsvd                <= 3'h0;
            ctl_q.output_level_bit    <= 1'b0;
        end else if (wr && hit(idx, `CCT_IDX_CTL)) begin
            ctl_q.cap_irq_enable      <= wb_dat_i[`CCT_BIT_CAP];
            ctl_q.compare_irq_enable  <= wb_dat_i[`CCT_BIT_CMP];
            ctl_q.overflow_irq_enable <= wb_dat_i[`CCT_BIT_OVF];
            ctl_q.capture_edge_select <= wb_dat_i[`CCT_BIT_EDGE];
            ctl_q.output_level_bit    <= wb_dat_i[`CCT_BIT_LEVEL];
        end
    end

    // ----------------------------------------
    // capture
    // ----------------------------------------
    // latch count, unless inhibited
    always_ff @(posedge clk) begin
        if (cap_evt && !cap_inh_q) begin
            cap_q <= cnt_q;
        end
    end

    // inhibit from high read to low read
    always_ff @(posedge clk) begin
        if (rst) begin
            cap_inh_q <= 1'b0;
        end else if (rd && hit(idx, `CCT_IDX_CAP_HI)) begin
            cap_inh_q <= 1'b1;
        end else if (rd && hit(idx, `CCT_IDX_CAP_LO)) begin
            cap_inh_q <= 1'b0;
        end
    end

    // ----------------------------------------
    // compare
    // ----------------------------------------
    // once per count value, inhibited
    assign cmp_match = tick & ~cmp_inh_q & (cnt_q == cmp_q);

    always_ff @(posedge clk) begin
        if (rst) begin
            cmp_q <= 16'h0000;
        end else if (wr && hit(idx, `CCT_IDX_CMP_HI)) begin
            cmp_q[15:8] <= wb_dat_i[7:0];
        end else if (wr && hit(idx, `CCT_IDX_CMP_LO)) begin
            cmp_q[7:0] <= wb_dat_i[7:0];
        end
    end

    // inhibit from high write to low write
    always_ff @(posedge clk) begin
        if (rst) begin
            cmp_inh_q <= 1'b0;
        end else if (wr && hit(idx, `CCT_IDX_CMP_HI)) begin
            cmp_inh_q <= 1'b1;
        end else if (wr && hit(idx, `CCT_IDX_CMP_LO)) begin
            cmp_inh_q <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            pin_q <= 1'b0;
        end else if (cmp_match) begin
            pin_q <= ctl_q.output_level_bit;
        end
    end

    // ----------------------------------------
    // counter read latches
    // ----------------------------------------
    // freeze low byte after high read
    always_ff @(posedge clk) begin
        if (rst) begin
            cnt_frz_q <= 1'b0;
            cnt_lat_q <= 8'h00;
        end else if (rd && hit(idx, `CCT_IDX_CNT_HI)) begin
            cnt_frz_q <= 1'b1;
            cnt_lat_q <= cnt_q[7:0];
        end else if (rd && hit(idx, `CCT_IDX_CNT_LO)) begin
            cnt_frz_q <= 1'b0;
        end
    end

    // second view with its own latch
    always_ff @(posedge clk) begin
        if (rst) begin
            alt_frz_q <= 1'b0;
            alt_lat_q <= 8'h00;
        end else if (rd && hit(idx, `CCT_IDX_ALT_HI)) begin
            alt_frz_q <= 1'b1;
            alt_lat_q <= cnt_q[7:0];
        end else if (rd && hit(idx, `CCT_IDX_ALT_LO)) begin
            alt_frz_q <= 1'b0;
        end
    end

    // ----------------------------------------
    // flags and clear sequence
    // ----------------------------------------
    // status read arms the clear of each flag it saw set
    always_ff @(posedge clk) begin
        if (rst) begin
            arm_cap_q <= 1'b0;
            arm_cmp_q <= 1'b0;
            arm_ovf_q <= 1'b0;
        end else if (rd && hit(idx, `CCT_IDX_FLG)) begin
            arm_cap_q <= flg_q.capture_flag;
            arm_cmp_q <= flg_q.compare_flag;
            arm_ovf_q <= flg_q.overflow_flag;
        end else begin
            if (rd && hit(idx, `CCT_IDX_CAP_LO)) begin
                arm_cap_q <= 1'b0;
            end
            if (acc && hit(idx, `CCT_IDX_CMP_LO)) begin
                arm_cmp_q <= 1'b0;
            end
            if (rd && hit(idx, `CCT_IDX_CNT_LO)) begin
                arm_ovf_q <= 1'b0;
            end
        end
    end

    logic clr_cap;
    logic clr_cmp;
    logic clr_ovf;
    logic w1c;

    assign w1c     = wr & hit(idx, `CCT_IDX_FLG);
    // capture low read after armed status read
    assign clr_cap = (rd & arm_cap_q & hit(idx, `CCT_IDX_CAP_LO)) | (w1c & wb_dat_i[`CCT_BIT_CAP]);
    // compare low read or write after armed status read
    assign clr_cmp = (acc & arm_cmp_q & hit(idx, `CCT_IDX_CMP_LO)) | (w1c & wb_dat_i[`CCT_BIT_CMP]);
    // counter low read or write-one to status, second view excluded
    assign clr_ovf = (rd & arm_ovf_q & hit(idx, `CCT_IDX_CNT_LO)) | (w1c & wb_dat_i[`CCT_BIT_OVF]);

    always_ff @(posedge clk) begin
        flg_q.rsvd <= 5'h00;
        if (cap_evt) begin
            flg_q.capture_flag <= 1'b1;
        end else if (clr_cap) begin
            flg_q.capture_flag <= 1'b0;
        end
        if (cmp_match) begin
            flg_q.compare_flag <= 1'b1;
        end else if (clr_cmp) begin
            flg_q.compare_flag <= 1'b0;
        end
        if (wrap) begin
            flg_q.overflow_flag <= 1'b1;
        end else if (clr_ovf) begin
            flg_q.overflow_flag <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= (flg_q.capture_flag & ctl_q.cap_irq_enable)
                   | (flg_q.compare_flag & ctl_q.compare_irq_enable)
                   | (flg_q.overflow_flag & ctl_q.overflow_irq_enable);
        end
    end

    // ----------------------------------------
    // read mux and acknowledge
    // ----------------------------------------
    // byte views of each 16-bit value
    always_comb begin
        rdata = 8'h00;
        if (hit(idx, `CCT_IDX_CTL)) begin
            rdata = ctl_q;
        end else if (hit(idx, `CCT_IDX_FLG)) begin
            rdata = flg_q;
        end else if (hit(idx, `CCT_IDX_CAP_HI)) begin
            rdata = cap_q[15:8];
        end else if (hit(idx, `CCT_IDX_CAP_LO)) begin
            rdata = cap_q[7:0];
        end else if (hit(idx, `CCT_IDX_CMP_HI)) begin
            rdata = cmp_q[15:8];
        end else if (hit(idx, `CCT_IDX_CMP_LO)) begin
            rdata = cmp_q[7:0];
        end else if (hit(idx, `CCT_IDX_CNT_HI) || hit(idx, `CCT_IDX_ALT_HI)) begin
            rdata = cnt_q[15:8];
        end else if (hit(idx, `CCT_IDX_CNT_LO)) begin
            rdata = cnt_frz_q ? cnt_lat_q : cnt_q[7:0];
        end else if (hit(idx, `CCT_IDX_ALT_LO)) begin
            rdata = alt_frz_q ? alt_lat_q : cnt_q[7:0];
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            ack_q <= 1'b0;
            dat_q <= 32'h00000000;
        end else begin
            ack_q <= acc;
            if (rd) begin
                dat_q <= {24'h000000, rdata};
            end
        end
    end

    assign wb_ack_o        = ack_q;
    assign wb_dat_o        = dat_q;
    assign compare_out_pin = pin_q;
    assign timer_irq       = irq_q;

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    count_step_a: assert property (tick |=> cnt_q == $past(cnt_q) + 16'h0001)
        else $error("counter did not step on prescale tick");
    count_hold_a: assert property (!tick && !$past(rst) |=> $stable(cnt_q))
        else $error("counter moved between ticks");
    read_no_disturb_a: assert property (rd && !tick |=> $stable(cnt_q))
        else $error("counter read disturbed counting");
    capture_load_a: assert property (cap_evt && !cap_inh_q |=> cap_q == $past(cnt_q))
        else $error("capture did not latch count");
    capture_inhibit_a: assert property (cap_inh_q && !rd |=> $stable(cap_q))
        else $error("capture changed while inhibited");
    compare_pin_a: assert property (cmp_match |=> compare_out_pin == $past(ctl_q.output_level_bit))
        else $error("compare pin not driven to level");
    compare_once_a: assert property (cmp_match |-> ##1 !cmp_match [*3])
        else $error("compare matched twice within one count");
    compare_inhibit_a: assert property (cmp_inh_q |-> !cmp_match)
        else $error("compare matched while inhibited");
    cap_flag_set_a: assert property (cap_evt |=> flg_q.capture_flag)
        else $error("capture flag not set");
    cmp_flag_set_a: assert property (cmp_match |=> flg_q.compare_flag)
        else $error("compare flag not set");
    ovf_flag_set_a: assert property (wrap |=> flg_q.overflow_flag && cnt_q == 16'h0000)
        else $error("overflow flag not set on wrap");
    alt_no_clear_a: assert property (rd && hit(idx, `CCT_IDX_ALT_LO) && !w1c |=> $past(flg_q.overflow_flag) ? flg_q.overflow_flag : 1'b1)
        else $error("second view cleared overflow flag");
    freeze_hold_a: assert property (cnt_frz_q && !rd |=> $stable(cnt_lat_q))
        else $error("frozen low byte changed");
    irq_level_a: assert property (##1 timer_irq == $past((flg_q.capture_flag & ctl_q.cap_irq_enable) | (flg_q.compare_flag & ctl_q.compare_irq_enable) | (flg_q.overflow_flag & ctl_q.overflow_irq_enable)))
        else $error("interrupt does not follow flags and enables");
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held more than one cycle");

    capture_seen_c: cover property (cap_evt ##1 flg_q.capture_flag);
    compare_seen_c: cover property (cmp_match ##1 compare_out_pin);
    wrap_seen_c: cover property (wrap ##1 flg_q.overflow_flag);
    flag_cleared_c: cover property (clr_cap ##1 !flg_q.capture_flag);

endmodule : cct_timer

// ---- cct_pin_model.sv ----
// far-side model: drives the capture pin and watches the compare pin
`timescale 1ns/1ps
module cct_pin_model (
    // clock
    input  wire logic clk,
    // level asked for on the capture pin
    input  wire logic want_level,
    // pins
    output logic      capture_in_pin,
    input  wire logic compare_out_pin,
    // index of the edge at which the compare pin was last seen changed
    output int        cmp_edge
);
    int   n;
    logic last_q;

    initial begin
        n = 0;
        cmp_edge = 0;
        last_q = 1'b0;
        capture_in_pin = 1'b0;
    end

    // ----------------------------------------
    // pin driving and compare pin watch
    // ----------------------------------------
    // pin changes just after an edge and holds at least one full cycle
    always @(posedge clk) begin
        n <= n + 1;
        capture_in_pin <= want_level;
        if (compare_out_pin !== last_q) begin
            cmp_edge <= n;
        end
        last_q <= compare_out_pin;
    end
endmodule : cct_pin_model

// ---- cct_timer_test.sv ----
// self-checking bench for the capture/compare timer
`timescale 1ns/1ps
`include "cct_map.svh"
module cct_timer_test;
    logic        clk, rst, cyc, stb, we, ack, want, cap_pin, cmp_pin, irq;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] wdat, rdat;
    logic [15:0] exp_q[$];
    logic [15:0] nv, cap_v, c1, c2;
    int          n_mismatch, checks, cyc_cnt, rel, cmp_edge;

    cct_timer i_dut (.clk(clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .capture_in_pin(cap_pin),
        .compare_out_pin(cmp_pin), .timer_irq(irq));
    cct_pin_model i_pins (.clk(clk), .want_level(want), .capture_in_pin(cap_pin),
        .compare_out_pin(cmp_pin), .cmp_edge(cmp_edge));

    always #25 clk = ~clk;
    always @(posedge clk) cyc_cnt <= cyc_cnt + 1;

    task automatic check(input logic [31:0] seen, input logic [31:0] expv);
        checks++;
        if (seen !== expv) begin
            n_mismatch++;
            $display("Error at %0t: seen %h expected %h", $time, seen, expv);
        end
    endtask : check

    task automatic give_verdict;
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : give_verdict

    // ----------------------------------------
    // scoreboard: read data against the oldest note
    // ----------------------------------------
    always @(posedge clk) begin
        if (ack === 1'b1 && we === 1'b0) begin
            nv = exp_q.pop_front();
            check({24'h0, rdat[7:0] & nv[15:8]}, {24'h0, nv[7:0] & nv[15:8]});
        end
    end

    // counter value seen at the edge with this index
    function automatic logic [15:0] cnt(input int j);
        return 16'((j - rel) / 4);
    endfunction : cnt

    task automatic xfer(input logic w, input logic [5:0] idx, input logic [7:0] d, input logic [15:0] me);
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        sel <= 4'h1;
        adr <= {idx, 2'b00};
        wdat <= {24'($urandom), d};
        if (!w) exp_q.push_back(me);
        do @(posedge clk); while (ack !== 1'b1);
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask : xfer

    task automatic rd(input logic [5:0] idx, input logic [7:0] m, input logic [7:0] e);
        xfer(1'b0, idx, 8'h00, {m, e});
    endtask : rd

    task automatic wr(input logic [5:0] idx, input logic [7:0] d);
        xfer(1'b1, idx, d, 16'h0000);
    endtask : wr

    task automatic chk_irq(input logic e);
        repeat (2) @(posedge clk);
        check({31'h0, irq}, {31'h0, e});
    endtask : chk_irq

    // pin change lands where latch delay 3..6 edges stays inside one count
    task automatic set_pin(input logic l);
        do @(posedge clk); while ((cyc_cnt - rel) % 4 != 0);
        want <= l;
        cap_v = cnt(cyc_cnt + 4);
        repeat (8) @(posedge clk);
    endtask : set_pin

    // high read latches low byte; gap and ignored write in between
    task automatic cnt_pair(input logic [5:0] hi, input int gap);
        logic [15:0] c;
        c = cnt(cyc_cnt + 2);
        rd(hi, 8'hff, c[15:8]);
        repeat (gap) @(posedge clk);
        wr(hi + 6'h01, 8'($urandom));
        rd(hi + 6'h01, 8'hff, c[7:0]);
    endtask : cnt_pair

    task automatic cmp_run(input logic lvl, input logic full);
        logic [15:0] v;
        int          j;
        v = cnt(cyc_cnt + 2) + 16'(20 + $urandom_range(15));
        j = rel + 4 * int'(v) + 3;
        wr(`CCT_IDX_CMP_HI, v[15:8]);
        if (full) wr(`CCT_IDX_CMP_LO, v[7:0]);
        while (cyc_cnt < j + 6) @(posedge clk);
        check({31'h0, cmp_pin}, {31'h0, full ? lvl : ~lvl});
        if (full) check({31'h0, cmp_edge >= j + 1 && cmp_edge <= j + 2}, 32'h1);
    endtask : cmp_run

    initial begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        give_verdict();
    end

    initial begin
        clk = 1'b0;
        rst = 1'b1;
        {cyc, stb, we, want} = 4'h0;
        adr = 8'h00;
        sel = 4'h0;
        wdat = 32'h0;
        {n_mismatch, checks, cyc_cnt, rel} = '0;
        void'($urandom(65041));
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        rel = cyc_cnt + 1;
        // ----------------------------------------
        // reset values, access kinds, unmapped place
        // ----------------------------------------
        rd(`CCT_IDX_CTL, 8'he1, 8'h00);
        rd(6'h00, 8'hff, 8'h00);
        wr(`CCT_IDX_FLG, 8'he0);
        wr(`CCT_IDX_CTL, 8'he3);
        rd(`CCT_IDX_CTL, 8'he3, 8'he3);
        rd(`CCT_IDX_FLG, 8'he0, 8'h00);
        wr(`CCT_IDX_CTL, 8'h02);
        cnt_pair(`CCT_IDX_CNT_HI, $urandom_range(40, 5));
        cnt_pair(`CCT_IDX_ALT_HI, $urandom_range(40, 5));
        // ----------------------------------------
        // capture: rising, mask, inhibit, read-sequence clear
        // ----------------------------------------
        wr(`CCT_IDX_CTL, 8'h82);
        set_pin(1'b1);
        c1 = cap_v;
        chk_irq(1'b1);
        wr(`CCT_IDX_CTL, 8'h02);
        chk_irq(1'b0);
        wr(`CCT_IDX_CAP_LO, 8'($urandom));
        rd(`CCT_IDX_CAP_HI, 8'hff, c1[15:8]);
        set_pin(1'b0);
        set_pin(1'b1);
        rd(`CCT_IDX_FLG, 8'h80, 8'h80);
        rd(`CCT_IDX_CAP_LO, 8'hff, c1[7:0]);
        rd(`CCT_IDX_FLG, 8'h80, 8'h00);
        // falling edge selected
        wr(`CCT_IDX_CTL, 8'h80);
        set_pin(1'b0);
        c2 = cap_v;
        chk_irq(1'b1);
        rd(`CCT_IDX_CAP_HI, 8'hff, c2[15:8]);
        rd(`CCT_IDX_CAP_LO, 8'hff, c2[7:0]);
        wr(`CCT_IDX_FLG, 8'h80);
        chk_irq(1'b0);
        // ----------------------------------------
        // compare: level high, flag clear, inhibit, level low
        // ----------------------------------------
        wr(`CCT_IDX_CTL, 8'h43);
        cmp_run(1'b1, 1'b1);
        chk_irq(1'b1);
        rd(`CCT_IDX_FLG, 8'h40, 8'h40);
        rd(`CCT_IDX_CMP_LO, 8'h00, 8'h00);
        rd(`CCT_IDX_FLG, 8'h40, 8'h00);
        chk_irq(1'b0);
        wr(`CCT_IDX_CTL, 8'h42);
        cmp_run(1'b0, 1'b0);
        cmp_run(1'b0, 1'b1);
        give_verdict();
    end
endmodule : cct_timer_test
